// ===== src/lbt_pkg.sv
// Constants shared by the latching backplane transceiver
package lbt_pkg;
  localparam int          LBT_SLICES        = 9;
  localparam int          LBT_CTRL_W        = 4;
  // Register byte offsets
  localparam logic [31:0] LBT_CTRL_ADDR     = 32'h0000_0000;
  localparam logic [31:0] LBT_STATUS_ADDR   = 32'h0000_0004;
  localparam logic [31:0] LBT_BUS_ADDR      = 32'h0000_0008;
  localparam logic [31:0] LBT_LOCAL_ADDR    = 32'h0000_000c;
  // Control field positions
  localparam int          LBT_CHIP_OFF_BIT  = 0;
  localparam int          LBT_TRANSMIT_BIT  = 1;
  localparam int          LBT_BYPASS_BIT    = 2;
  localparam int          LBT_RX_HOLD_BIT   = 3;
  // Status field positions
  localparam int          LBT_STAT_DRV_LSB  = 0;
  localparam int          LBT_STAT_RX_LSB   = 16;
  // Reset values
  localparam logic [3:0]  LBT_CTRL_RESET    = 4'h9;
  localparam logic [8:0]  LBT_DATA_RESET    = 9'h000;
  // AHB-Lite encodings
  localparam logic [1:0]  LBT_HTRANS_NONSEQ = 2'h2;
  localparam logic        LBT_HRESP_OKAY    = 1'h0;
endpackage : lbt_pkg

// ===== src/lbt_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module lbt_sync #(
  parameter int WIDTH = 9
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_syncOut;

  // A bit changes only once stages two and three agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_syncOut[i] = (stage2[i] == stage3[i]) ? stage2[i] : syncOut[i];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stage1  <= '0;
      stage2  <= '0;
      stage3  <= '0;
      syncOut <= '0;
    end else begin
      stage1  <= pinIn;
      stage2  <= stage1;
      stage3  <= stage2;
      syncOut <= next_syncOut;
    end
  end
endmodule : lbt_sync

// ===== src/lbt_transceiver.sv
// Nine-slice latching backplane transceiver with AHB-Lite control
//
// The AHB-Lite slave port and the address map were decided locally.
`timescale 1ns/10ps
module lbt_transceiver (
  input  wire logic                         clock,
  input  wire logic                         rst_n,
  // AHB-Lite slave
  input  wire logic                         hsel,
  input  wire logic [31:0]                  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [31:0]                  hwdata,
  input  wire logic                         hready,
  output logic                              hreadyout,
  output logic                              hresp,
  output logic      [31:0]                  hrdata,
  // Driver capture clock pin
  input  wire logic                         driverCaptureClk,
  // Local side port, three-state
  input  wire logic [lbt_pkg::LBT_SLICES-1:0] localIn,
  output logic      [lbt_pkg::LBT_SLICES-1:0] localOut,
  output logic      [lbt_pkg::LBT_SLICES-1:0] localOe,
  // Backplane side bus, open collector
  input  wire logic [lbt_pkg::LBT_SLICES-1:0] busIn,
  output logic      [lbt_pkg::LBT_SLICES-1:0] busOut,
  output logic      [lbt_pkg::LBT_SLICES-1:0] busOe
);
  import lbt_pkg::*;

  localparam int N = LBT_SLICES;

  logic [LBT_CTRL_W-1:0] ctrl;
  logic [LBT_CTRL_W-1:0] next_ctrl;
  logic                  wrPend;
  logic                  next_wrPend;
  logic [31:0]           wrAddr;
  logic [31:0]           next_wrAddr;
  logic [31:0]           next_hrdata;
  logic                  addrPhase;

  logic [N-1:0]          localSync;
  logic [N-1:0]          busSync;
  logic [0:0]            clkSync;
  logic                  clkPrev;
  logic                  next_clkPrev;
  logic                  captureEdge;
  logic [N-1:0]          drvQ;
  logic [N-1:0]          next_drvQ;
  logic [N-1:0]          rxLatch;
  logic [N-1:0]          next_rxLatch;
  logic [N-1:0]          next_busOe;
  logic [N-1:0]          next_localOe;

  logic                  chipOff;
  logic                  transmit;
  logic                  driverBypass;
  logic                  receiverHoldControl;
  logic                  txEn;
  logic                  rxEn;

  // Read multiplexer over the register map
  function automatic logic [31:0] readMux(input logic [31:0]           addr,
                                          input logic [LBT_CTRL_W-1:0] c,
                                          input logic [N-1:0]          d,
                                          input logic [N-1:0]          r,
                                          input logic [N-1:0]          b,
                                          input logic [N-1:0]          l);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (addr)
      LBT_CTRL_ADDR: begin
        v[LBT_CTRL_W-1:0] = c;
      end
      LBT_STATUS_ADDR: begin
        v[LBT_STAT_DRV_LSB +: N] = d;
        v[LBT_STAT_RX_LSB +: N]  = r;
      end
      LBT_BUS_ADDR: begin
        v[N-1:0] = b;
      end
      LBT_LOCAL_ADDR: begin
        v[N-1:0] = l;
      end
      default: begin
        v = 32'h0000_0000;
      end
    endcase
    return v;
  endfunction : readMux

  // Pin inputs cross into the clock domain
  lbt_sync #(.WIDTH(N)) uLocalSync (
    .clock   (clock),
    .rst_n   (rst_n),
    .pinIn   (localIn),
    .syncOut (localSync)
  );

  lbt_sync #(.WIDTH(N)) uBusSync (
    .clock   (clock),
    .rst_n   (rst_n),
    .pinIn   (busIn),
    .syncOut (busSync)
  );

  lbt_sync #(.WIDTH(1)) uClkSync (
    .clock   (clock),
    .rst_n   (rst_n),
    .pinIn   (driverCaptureClk),
    .syncOut (clkSync)
  );

  // Bus slave: zero wait state, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = LBT_HRESP_OKAY;
  assign addrPhase = hsel && hready && (htrans == LBT_HTRANS_NONSEQ);

  always_comb begin
    next_ctrl   = ctrl;
    next_wrPend = 1'b0;
    next_wrAddr = wrAddr;
    next_hrdata = hrdata;
    if (wrPend && (wrAddr == LBT_CTRL_ADDR)) begin
      next_ctrl = hwdata[LBT_CTRL_W-1:0];
    end
    if (addrPhase) begin
      next_wrPend = hwrite;
      next_wrAddr = haddr;
      if (!hwrite) begin
        next_hrdata = readMux(haddr, next_ctrl, drvQ, rxLatch, busSync, localSync);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl   <= LBT_CTRL_RESET;
      wrPend <= 1'b0;
      wrAddr <= 32'h0000_0000;
      hrdata <= 32'h0000_0000;
    end else begin
      ctrl   <= next_ctrl;
      wrPend <= next_wrPend;
      wrAddr <= next_wrAddr;
      hrdata <= next_hrdata;
    end
  end

  assign chipOff             = ctrl[LBT_CHIP_OFF_BIT];
  assign transmit            = ctrl[LBT_TRANSMIT_BIT];
  assign driverBypass        = ctrl[LBT_BYPASS_BIT];
  assign receiverHoldControl = ctrl[LBT_RX_HOLD_BIT];
  assign txEn                = !chipOff && transmit;
  assign rxEn                = !chipOff && !transmit;
  assign captureEdge         = clkSync[0] && !clkPrev;

  // Slice datapath, all nine bits side by side
  always_comb begin
    next_clkPrev = clkSync[0];
    next_drvQ    = drvQ;
    if (driverBypass) begin
      next_drvQ = localSync;
    end else if (captureEdge) begin
      next_drvQ = localSync;
    end
    next_rxLatch = receiverHoldControl ? busSync : rxLatch;
    next_busOe   = txEn ? ~drvQ : '0;
    next_localOe = rxEn ? '1 : '0;
  end

  assign busOut = '0;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      clkPrev  <= 1'b0;
      drvQ     <= LBT_DATA_RESET;
      rxLatch  <= LBT_DATA_RESET;
      busOe    <= '0;
      localOe  <= '0;
      localOut <= LBT_DATA_RESET;
    end else begin
      clkPrev  <= next_clkPrev;
      drvQ     <= next_drvQ;
      rxLatch  <= next_rxLatch;
      busOe    <= next_busOe;
      localOe  <= next_localOe;
      localOut <= next_rxLatch;
    end
  end

  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence txHeld;
    txEn [*2];
  endsequence

  sequence rxHeld;
    rxEn [*2];
  endsequence

  AST_BUS_PULLS_LOW_ONLY: assert property (
    (busOut == '0) && ((busOe & $past(drvQ)) == '0)
  ) else $error("Bus driven while driver bit is high");

  AST_CHIP_OFF_RELEASES: assert property (
    chipOff |=> (busOe == '0) && (localOe == '0)
  ) else $error("Chip off but a pin is still driven");

  AST_TX_DRIVES_BUS: assert property (
    txHeld |=> (busOe == ~$past(drvQ)) && (localOe == '0)
  ) else $error("Transmit does not place driver data on bus");

  AST_RX_DRIVES_LOCAL: assert property (
    rxHeld |=> (busOe == '0) && (localOe == '1) && (localOut == rxLatch)
  ) else $error("Receive does not release bus or drive local");

  AST_BYPASS_FOLLOWS: assert property (
    driverBypass |=> drvQ == $past(localSync)
  ) else $error("Bypass driver flop did not follow local input");

  AST_EDGE_CAPTURES: assert property (
    (!driverBypass && clkSync[0] && !clkPrev) |=> drvQ == $past(localSync)
  ) else $error("Capture edge did not load local input");

  AST_HOLD_BETWEEN_EDGES: assert property (
    (!driverBypass && !(clkSync[0] && !clkPrev)) |=> $stable(drvQ)
  ) else $error("Driver flop changed without a capture edge");

  AST_RX_TRANSPARENT: assert property (
    receiverHoldControl |=> rxLatch == $past(busSync)
  ) else $error("Receiver latch not transparent");

  AST_RX_RETAINS: assert property (
    (!receiverHoldControl) [*2] |=> $stable(rxLatch) && $stable(localOut)
  ) else $error("Receiver latch lost its held value");
endmodule : lbt_transceiver

// ===== verif/lbt_peer_model.sv
// Peer boards sharing the terminated wired-OR backplane
`timescale 1ns/10ps
module lbt_peer_model (
  input  wire logic       clock,
  input  wire logic       slow,
  input  wire logic [8:0] pullReq,
  input  wire logic [8:0] dutOe,
  input  wire logic [8:0] dutOut,
  output logic      [8:0] line
);
  logic [8:0] stage = 9'h000;
  logic [8:0] pull  = 9'h000;
  // Slow peers apply their pull two clocks late
  always @(posedge clock) begin
    stage <= pullReq;
    pull  <= slow ? stage : pullReq;
  end
  // Low when any board pulls, else held high by the terminations
  assign line = (~dutOe | dutOut) & ~pull;
endmodule : lbt_peer_model

// ===== verif/testbench.sv
// Self-checking bench for the latching backplane transceiver
`timescale 1ns/10ps
module testbench;
  import lbt_pkg::*;
  logic        clock, rst_n, hsel, hwrite, hreadyout, hresp, capClk, slow;
  logic        rdPhase = 1'b0;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [8:0]  localDrv, localIn, localOut, localOe, busLine, busOut, busOe, pullReq, d, e;
  logic [31:0] expQ[$];
  int          bad_count, n_checks, seed, i;

  lbt_transceiver lbt_transceiver_inst (.clock(clock), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .driverCaptureClk(capClk), .localIn(localIn), .localOut(localOut),
    .localOe(localOe), .busIn(busLine), .busOut(busOut), .busOe(busOe));
  lbt_peer_model lbt_peer_model_inst (.clock(clock), .slow(slow), .pullReq(pullReq),
    .dutOe(busOe), .dutOut(busOut), .line(busLine));
  // Local pin: the transceiver wins where it drives
  assign localIn = (localOe & localOut) | (~localOe & localDrv);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  task automatic waitReady;
    int k;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50) begin
      bad_count++;
      results();
    end
  endtask : waitReady

  // One single-word transfer; reads note the expected word for the monitor
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] v);
    if (!wr) expQ.push_back(v);
    htrans <= LBT_HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= wr;
    waitReady();
    htrans <= 2'h0;
    hwdata <= wr ? v : 32'h0;
    waitReady();
  endtask : ahb

  // Wait for the pins to reach the expected state, then compare
  task automatic settle(input logic [8:0] eBus, input logic [8:0] eOe, input logic [8:0] eOut);
    int k;
    for (k = 0; k < 60 && (busOe !== eBus || localOe !== eOe
         || (eOe[0] && localOut !== eOut)); k++) @(posedge clock);
    check("busOe", {23'h0, eBus}, {23'h0, busOe});
    check("localOe", {23'h0, eOe}, {23'h0, localOe});
    check("busOut", 32'h0, {23'h0, busOut});
    if (eOe[0]) check("localOut", {23'h0, eOut}, {23'h0, localOut});
    if (k == 60) results();
  endtask : settle

  // Monitor: each read data phase pops the oldest expected word
  always @(posedge clock) begin
    if (rdPhase && hreadyout === 1'b1) begin
      check("hrdata", expQ.pop_front(), hrdata);
      check("hresp", {31'h0, LBT_HRESP_OKAY}, {31'h0, hresp});
    end
    if (hreadyout === 1'b1) rdPhase <= hsel && htrans == LBT_HTRANS_NONSEQ && !hwrite;
  end

  initial begin
    seed = 51;
    bad_count = 0;
    n_checks = 0;
    rst_n = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    capClk = 1'b0;
    slow = 1'b0;
    localDrv = 9'h000;
    pullReq = 9'h000;
    tick(2);
    rst_n <= 1'b1;
    ahb(0, LBT_CTRL_ADDR, {28'h0, LBT_CTRL_RESET});
    ahb(1, 32'h0000_0010, 32'hffff_ffff);
    ahb(0, 32'h0000_0010, 32'h0);
    settle(9'h000, 9'h000, 9'h000);
    $display("test reset done");
    ahb(1, LBT_CTRL_ADDR, 32'h6);
    for (i = 0; i < 4; i++) begin
      d = 9'($random(seed));
      e = 9'($random(seed));
      slow <= i[0];
      localDrv <= d;
      pullReq <= e;
      settle(~d, 9'h000, 9'h000);
      tick(10);
      ahb(0, LBT_BUS_ADDR, {23'h0, d & ~e});
      ahb(0, LBT_LOCAL_ADDR, {23'h0, d});
    end
    $display("test fall-through done");
    pullReq <= 9'h000;
    ahb(1, LBT_CTRL_ADDR, 32'h2);
    ahb(0, LBT_CTRL_ADDR, 32'h2);
    localDrv <= ~d;
    tick(20);
    settle(~d, 9'h000, 9'h000);
    capClk <= 1'b1;
    tick(4);
    capClk <= 1'b0;
    settle(d, 9'h000, 9'h000);
    $display("test capture done");
    pullReq <= 9'h0a5;
    ahb(1, LBT_CTRL_ADDR, 32'h8);
    settle(9'h000, 9'h1ff, 9'h15a);
    ahb(1, LBT_CTRL_ADDR, 32'h0);
    pullReq <= 9'h13c;
    tick(20);
    settle(9'h000, 9'h1ff, 9'h15a);
    ahb(1, LBT_CTRL_ADDR, 32'h8);
    settle(9'h000, 9'h1ff, 9'h0c3);
    $display("test receive done");
    ahb(1, LBT_CTRL_ADDR, 32'h3);
    settle(9'h000, 9'h000, 9'h000);
    $display("test chip off done");
    results();
  end
endmodule : testbench
